// ==== src/lvs_serializer.sv ====
`timescale 1ns/1ps
`default_nettype none


module lvs_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic wrClk,
  input wire logic wrRst_n,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdClk,
  input wire logic rdRst_n,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrBin_reg;
  logic [AW:0] wrGray_reg;
  logic [AW:0] rdBin_reg;
  logic [AW:0] rdGray_reg;
  logic [AW:0] rdGraySync1_reg;
  logic [AW:0] rdGraySync2_reg;
  logic [AW:0] wrGraySync1_reg;
  logic [AW:0] wrGraySync2_reg;
  logic [AW:0] wrBin_next;
  logic [AW:0] rdBin_next;
  logic wrFire;
  logic rdFire;

  assign wrReady = (wrGray_reg != {~rdGraySync2_reg[AW:AW-1], rdGraySync2_reg[AW-2:0]});
  assign rdValid = (rdGray_reg != wrGraySync2_reg);
  assign wrFire = wrValid && wrReady;
  assign rdFire = rdValid && rdReady;
  assign wrBin_next = wrBin_reg + (AW+1)'(wrFire);
  assign rdBin_next = rdBin_reg + (AW+1)'(rdFire);
  assign rdData = mem[rdBin_reg[AW-1:0]];

  always_ff @(posedge wrClk) begin
    if (wrFire) begin
      mem[wrBin_reg[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge wrClk or negedge wrRst_n) begin
    if (!wrRst_n) begin
      wrBin_reg <= '0;
      wrGray_reg <= '0;
      rdGraySync1_reg <= '0;
      rdGraySync2_reg <= '0;
    end else begin
      wrBin_reg <= wrBin_next;
      wrGray_reg <= wrBin_next ^ (wrBin_next >> 1);
      rdGraySync1_reg <= rdGray_reg;
      rdGraySync2_reg <= rdGraySync1_reg;
    end
  end

  always_ff @(posedge rdClk or negedge rdRst_n) begin
    if (!rdRst_n) begin
      rdBin_reg <= '0;
      rdGray_reg <= '0;
      wrGraySync1_reg <= '0;
      wrGraySync2_reg <= '0;
    end else begin
      rdBin_reg <= rdBin_next;
      rdGray_reg <= rdBin_next ^ (rdBin_next >> 1);
      wrGraySync1_reg <= wrGray_reg;
      wrGraySync2_reg <= wrGraySync1_reg;
    end
  end
endmodule

module lvs_serializer
  import lvs_pkg::*;
#(
  parameter int LOCK_CYCLES = LVS_LOCK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic input_pixel_clock,
  input wire logic power_down_clear_n,
  input wire logic [LVS_WIDTH-1:0] parallel_data_in,
  output logic capture_ready,
  output logic [LVS_LANES-1:0] serial_lane_pair_p,
  output logic [LVS_LANES-1:0] serial_lane_pair_n,
  output logic forwarded_lane_clock_p,
  output logic forwarded_lane_clock_n,
  output logic lane_drive_en,
  output logic lane_data_valid
);
  logic clearAll_n;
  logic pixClkFall;
  logic pixRstSync1_reg;
  logic pixRst_n_reg;
  logic sysRstSync1_reg;
  logic sysRst_n_reg;
  logic [LVS_WIDTH-1:0] capture_reg;
  logic captureValid_reg;
  logic fifoValid;
  logic fifoReady;
  logic [LVS_WIDTH-1:0] fifoData;
  logic [2:0] bitPos_reg;
  logic [2:0] bitPos_next;
  logic sliceStart;
  logic lastBit;
  logic [LVS_SLICE-1:0] shift_reg [LVS_LANES];
  logic [LVS_LANES-1:0] laneBit_reg;
  logic fwdClk_reg;
  logic driveEn_reg;
  logic [LVS_SLICE-1:0] clkShift_reg;
  lvs_state_t state_reg;
  lvs_state_t state_next;
  logic [$clog2(LOCK_CYCLES+1)-1:0] lockCnt_reg;
  logic [$clog2(LOCK_CYCLES+1)-1:0] lockCnt_next;
  logic lockDone;

  // power-down and reset both clear asynchronously; release is synchronised per domain
  assign clearAll_n = rst_n && power_down_clear_n;
  assign pixClkFall = ~input_pixel_clock;

  always_ff @(posedge pixClkFall or negedge clearAll_n) begin
    if (!clearAll_n) begin
      pixRstSync1_reg <= 1'b0;
      pixRst_n_reg <= 1'b0;
    end else begin
      pixRstSync1_reg <= 1'b1;
      pixRst_n_reg <= pixRstSync1_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge clearAll_n) begin
    if (!clearAll_n) begin
      sysRstSync1_reg <= 1'b0;
      sysRst_n_reg <= 1'b0;
    end else begin
      sysRstSync1_reg <= 1'b1;
      sysRst_n_reg <= sysRstSync1_reg;
    end
  end

  // capture the whole word on each falling edge of the pixel clock
  always_ff @(posedge pixClkFall or negedge pixRst_n_reg) begin
    if (!pixRst_n_reg) begin
      capture_reg <= '0;
      captureValid_reg <= 1'b0;
    end else begin
      capture_reg <= parallel_data_in;
      captureValid_reg <= 1'b1;
    end
  end

  // a cleared pixel side takes no word, so ready stays low through power-down
  assign capture_ready = fifoReady && pixRst_n_reg;

  lvs_fifo #(
    .WIDTH(LVS_WIDTH),
    .DEPTH(LVS_FIFO_DEPTH)
  ) u_fifo (
    .wrClk(pixClkFall),
    .wrRst_n(pixRst_n_reg),
    .wrValid(captureValid_reg),
    .wrReady(fifoReady),
    .wrData(capture_reg),
    .rdClk(sys_clk),
    .rdRst_n(sysRst_n_reg),
    .rdValid(fifoValid),
    .rdReady(sliceStart),
    .rdData(fifoData)
  );

  // one word is unloaded per seven bit times
  assign lastBit = (bitPos_reg == LVS_LAST_BIT);
  assign sliceStart = (bitPos_reg == 3'h0);
  assign bitPos_next = lastBit ? 3'h0 : bitPos_reg + 3'h1;

  always_ff @(posedge sys_clk or negedge sysRst_n_reg) begin
    if (!sysRst_n_reg) begin
      bitPos_reg <= 3'h0;
      clkShift_reg <= LVS_SHIFT_RESET;
    end else begin
      bitPos_reg <= bitPos_next;
      clkShift_reg <= sliceStart ? LVS_CLK_PATTERN : clkShift_reg >> 1;
    end
  end

  generate
    for (genvar lane = 0; lane < LVS_LANES; lane++) begin : g_lane
      logic [LVS_SLICE-1:0] laneSlice;
      // an empty buffer sends an all-zero slice so the clock lane never stalls
      assign laneSlice = fifoValid ? fifoData[lane*LVS_SLICE +: LVS_SLICE] : '0;
      always_ff @(posedge sys_clk or negedge sysRst_n_reg) begin
        if (!sysRst_n_reg) begin
          shift_reg[lane] <= LVS_SHIFT_RESET;
          laneBit_reg[lane] <= 1'b0;
        end else begin
          shift_reg[lane] <= sliceStart ? laneSlice >> 1 : shift_reg[lane] >> 1;
          laneBit_reg[lane] <= sliceStart ? laneSlice[0] : shift_reg[lane][0];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge sysRst_n_reg) begin
    if (!sysRst_n_reg) begin
      fwdClk_reg <= 1'b0;
      driveEn_reg <= 1'b0;
    end else begin
      fwdClk_reg <= sliceStart ? LVS_CLK_PATTERN[0] : clkShift_reg[1];
      driveEn_reg <= 1'b1;
    end
  end

  // lock wait after leaving power-down
  assign lockDone = (lockCnt_reg == ($clog2(LOCK_CYCLES+1))'(LOCK_CYCLES - 1));
  assign lockCnt_next = (state_reg == LVS_LOCKING) ? lockCnt_reg + 1'b1 : lockCnt_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LVS_LOCKING: begin
        if (lockDone) begin
          state_next = LVS_RUNNING;
        end
      end
      LVS_RUNNING: begin
        state_next = LVS_RUNNING;
      end
      default: begin
        state_next = LVS_LOCKING;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge sysRst_n_reg) begin
    if (!sysRst_n_reg) begin
      state_reg <= LVS_LOCKING;
      lockCnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      lockCnt_reg <= lockCnt_next;
    end
  end

  // the async clear gates the drivers directly so the off state needs no clock edge
  assign lane_drive_en = driveEn_reg && clearAll_n;
  assign serial_lane_pair_p = lane_drive_en ? laneBit_reg : '0;
  assign serial_lane_pair_n = lane_drive_en ? ~laneBit_reg : '0;
  assign forwarded_lane_clock_p = lane_drive_en && fwdClk_reg;
  assign forwarded_lane_clock_n = lane_drive_en && !fwdClk_reg;
  assign lane_data_valid = (state_reg == LVS_RUNNING) && lane_drive_en;
endmodule

`default_nettype wire

// ==== src/lvs_pkg.sv ====
package lvs_pkg;
  localparam int LVS_LANES = 3;
  localparam int LVS_SLICE = 7;
  localparam int LVS_WIDTH = LVS_LANES * LVS_SLICE;
  localparam int LVS_FIFO_DEPTH = 8;
  localparam int LVS_SYNC_STAGES = 2;
  // forwarded clock slice, bit position 0 first: four high, three low
  localparam logic [6:0] LVS_CLK_PATTERN = 7'h0f;
  localparam logic [2:0] LVS_LAST_BIT = 3'h6;
  localparam logic [6:0] LVS_SHIFT_RESET = 7'h00;
  localparam int LVS_SYS_CLK_KHZ = 125000;
  localparam int LVS_LOCK_TIME_MS = 1;
  localparam int LVS_LOCK_CYCLES = LVS_LOCK_TIME_MS * LVS_SYS_CLK_KHZ;
  typedef enum logic [0:0] {
    LVS_LOCKING,
    LVS_RUNNING
  } lvs_state_t;
endpackage

// ==== sim/lvs_serializer_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module lvs_serializer_monitor
  import lvs_pkg::*;
#(
  parameter int LOCK_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic power_down_clear_n,
  input wire logic [LVS_LANES-1:0] serial_lane_pair_p,
  input wire logic [LVS_LANES-1:0] serial_lane_pair_n,
  input wire logic forwarded_lane_clock_p,
  input wire logic forwarded_lane_clock_n,
  input wire logic lane_drive_en,
  input wire logic lane_data_valid
);
  logic [15:0] upCnt_reg;
  always_ff @(posedge sys_clk or negedge rst_n or negedge power_down_clear_n) begin
    if (!rst_n || !power_down_clear_n) upCnt_reg <= 16'h0000;
    else if (upCnt_reg != 16'hffff) upCnt_reg <= upCnt_reg + 16'h0001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!(rst_n && power_down_clear_n));
  sequence fwdHigh3;
    forwarded_lane_clock_p [*3];
  endsequence
  sequence fwdLow3;
    !forwarded_lane_clock_p [*3];
  endsequence
  off_in_down_a: assert property (disable iff (!rst_n)
    !power_down_clear_n |-> !lane_drive_en && !forwarded_lane_clock_p && serial_lane_pair_p == '0)
    else $error("outputs on in power-down");
  clk_shape_a: assert property ($rose(forwarded_lane_clock_p) && $past(lane_drive_en)
    |=> fwdHigh3 ##1 fwdLow3 ##1 forwarded_lane_clock_p) else $error("clock lane shape");
  pair_comp_a: assert property (lane_drive_en |-> serial_lane_pair_n == ~serial_lane_pair_p
    && forwarded_lane_clock_n == !forwarded_lane_clock_p) else $error("pair not complementary");
  off_quiet_a: assert property (!lane_drive_en |-> serial_lane_pair_p == '0
    && serial_lane_pair_n == '0 && !forwarded_lane_clock_p) else $error("lanes driven while off");
  valid_drive_a: assert property (lane_data_valid |-> lane_drive_en) else $error("valid off");
  lock_min_a: assert property ($rose(lane_data_valid) |-> upCnt_reg >= LOCK_CYCLES - 1)
    else $error("valid before lock");
  lock_max_a: assert property (upCnt_reg == LOCK_CYCLES + 4 |-> lane_data_valid)
    else $error("valid late");
  drive_hold_a: assert property (lane_drive_en |=> lane_drive_en) else $error("drivers dropped");
endmodule
bind lvs_serializer lvs_serializer_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) u_mon (.sys_clk, .rst_n,
  .power_down_clear_n, .serial_lane_pair_p, .serial_lane_pair_n, .forwarded_lane_clock_p,
  .forwarded_lane_clock_n, .lane_drive_en, .lane_data_valid);
`default_nettype wire

// ==== sim/lvs_link_receiver.sv ====
`timescale 1ns/1ps
`default_nettype none
module lvs_link_receiver
  import lvs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [LVS_LANES-1:0] lanes,
  input wire logic fwdClk,
  input wire logic lockOk,
  output logic [LVS_WIDTH-1:0] word,
  output logic wordStrobe
);
  logic [LVS_WIDTH-1:0] acc = '0;
  logic prevClk = 1'b0;
  int pos = 7;
  initial wordStrobe = 1'b0;
  initial word = '0;
  always @(negedge sys_clk) begin
    wordStrobe <= 1'b0;
    if (fwdClk && !prevClk) pos = 0;
    if (pos < 7) begin
      for (int l = 0; l < LVS_LANES; l++) acc[l*LVS_SLICE+pos] = lanes[l];
      if (pos == 6) begin
        word <= acc;
        wordStrobe <= lockOk;
      end
    end
    prevClk = fwdClk;
    pos = pos + 1;
  end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top import lvs_pkg::*;;
  localparam int LOCK = 20;
  logic sys_clk = 1'b0;
  logic input_pixel_clock = 1'b0;
  logic rst_n = 1'b0;
  logic power_down_clear_n = 1'b1;
  logic [LVS_WIDTH-1:0] parallel_data_in = '0;
  logic capture_ready, forwarded_lane_clock_p, forwarded_lane_clock_n;
  logic lane_drive_en, lane_data_valid, rxStb;
  logic [LVS_LANES-1:0] serial_lane_pair_p, serial_lane_pair_n;
  logic [LVS_WIDTH-1:0] rxWord;
  logic [LVS_WIDTH-1:0] sent[$];
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int rxCount = 0;
  always #4 sys_clk = ~sys_clk;
  always #15 input_pixel_clock = ~input_pixel_clock;
  lvs_serializer #(.LOCK_CYCLES(LOCK)) u_dut (.sys_clk, .rst_n, .input_pixel_clock,
    .power_down_clear_n, .parallel_data_in, .capture_ready, .serial_lane_pair_p,
    .serial_lane_pair_n, .forwarded_lane_clock_p, .forwarded_lane_clock_n, .lane_drive_en,
    .lane_data_valid);
  lvs_link_receiver u_rx (.sys_clk, .lanes(serial_lane_pair_p), .fwdClk(forwarded_lane_clock_p),
    .lockOk(lane_data_valid), .word(rxWord), .wordStrobe(rxStb));
  task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge input_pixel_clock) parallel_data_in <= LVS_WIDTH'($urandom);
  always @(negedge input_pixel_clock) begin
    if (rst_n && power_down_clear_n) sent.push_back(parallel_data_in);
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      conclude();
    end
    if (rxStb === 1'b1 && rxWord !== '0) begin
      // skip words dropped at a full buffer, order must hold
      while (sent.size() > 0 && sent[0] !== rxWord) void'(sent.pop_front());
      check("lane word", sent.size() > 0 ? sent[0] : ~rxWord, rxWord);
      if (sent.size() > 0) void'(sent.pop_front());
      rxCount++;
    end
  end
  initial begin
    void'($urandom(76));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (LOCK - 3) @(posedge sys_clk);
    #1 check("valid early", '0, 21'(lane_data_valid));
    repeat (10) @(posedge sys_clk);
    #1 check("valid late", 21'h1, 21'(lane_data_valid));
    $display("lock test done");
    repeat (600) @(posedge sys_clk);
    check("words seen", 21'h1, 21'(rxCount > 20));
    $display("stream test done");
    power_down_clear_n <= 1'b0;
    @(posedge sys_clk);
    #1 check("pd off", '0, 21'({capture_ready, lane_drive_en, lane_data_valid,
      forwarded_lane_clock_p, serial_lane_pair_p, serial_lane_pair_n}));
    sent.delete();
    rxCount = 0;
    repeat (10) @(posedge sys_clk);
    power_down_clear_n <= 1'b1;
    repeat (LOCK + 600) @(posedge sys_clk);
    check("words after pd", 21'h1, 21'(rxCount > 20));
    $display("power-down test done");
    conclude();
  end
endmodule
`default_nettype wire
